// >>> inc/soc_address_decoder_defs.vh
// Constants for the platform hub address decoder: route codes, fixed
// windows and legacy port slots. Assumes inclusion by design and testbench files.
//
// What this block does
// - Low memory and one-meg-to-top go to DRAM.
// - E segment to firmware when bit 6 set.
// - F segment to firmware when bit 7 set.
// - Upper 512K windows plus alias enabled by 8-14.
// - Topmost 512K window always firmware, swappable blocks.
// - Four 1M windows plus alias enabled by 0-3.
// - Internal APIC window gated by enable, select digits.
// - Eight 32K windows route to root ports.
// - Watchdog range sits 96 bytes above PM base.
// - Two 8-byte serial ranges, eight slots, to LPC.
// - Parallel range 8 bytes, three slots, to LPC.
// - Floppy range 8 bytes, two slots, to LPC.
// - LAN window A is 128K, base enabled.
// - LAN window B is 4K, base enabled.
// - EHCI window is 1K, base enabled.
// - Port 80 and write-only debug ports forward.
// - Legacy disk ports route to SATA path.
// - RTC/NMI ports split by direction and parity.
// - Native disk ranges go to SATA or redirection.
// - Swap mode inverts A16 in top blocks.
`ifndef SOC_ADDRESS_DECODER_DEFS_VH
`define SOC_ADDRESS_DECODER_DEFS_VH

// Route codes.
`define TGT_W 5
`define TGT_DEFAULT 5'h00
`define TGT_MAIN_MEM 5'h01
`define TGT_FW_PATH 5'h02
`define TGT_DMA 5'h03
`define TGT_DMA_FWD 5'h04
`define TGT_INTC 5'h05
`define TGT_TIMER 5'h06
`define TGT_RTC 5'h07
`define TGT_NMI_RTC 5'h08
`define TGT_NMI 5'h09
`define TGT_RESET_GEN 5'h0a
`define TGT_PM 5'h0b
`define TGT_SATA 5'h0c
`define TGT_LPC 5'h0d
`define TGT_APIC 5'h0e
`define TGT_ROOT_PORT 5'h0f
`define TGT_LAN 5'h10
`define TGT_EHCI 5'h11
`define TGT_WATCHDOG 5'h12
`define TGT_DISK_REDIR 5'h13
`define TGT_PROC_IF 5'h14

// Firmware decode enable bits.
`define FW_EN_W 16
`define FW_E_SEG_BIT 6
`define FW_F_SEG_BIT 7
`define FW_HI_BIT0 4'h8
`define FW_HI_TOP_IDX 3'h7

// Memory map constants.
`define LOW_MEM_END 32'h000e0000
`define ONE_MEG 32'h00100000
`define E_SEG_PAGE 16'h000e
`define F_SEG_PAGE 16'h000f
`define FW_HI_TAG 10'h3ff
`define FW_HI_ALIAS_TAG 10'h3fe
`define FW_LO_TAG 9'h1fe
`define APIC_TAG 12'hfec
`define APIC_WIN_LAST 12'h040
`define RP_FIRST_SLOT 5'h02
`define RP_LAST_SLOT 5'h09
`define SWAP_ADDR_BIT 16
`define SWAP_BLOCKS 2'h3

// I/O constants.
`define IO_W 16
`define TCO_OFFSET 16'h0060
`define TCO_SIZE_LOG2 5
`define PM_SIZE_LOG2 6
`define LEG_SIZE_LOG2 3
`define DISK_CMD_LOG2 3
`define DISK_CTL_LOG2 2
`define LAN_A_LOG2 17
`define LAN_B_LOG2 12
`define EHCI_LOG2 10

// Legacy slots, eight 16-bit bases, slot 0 in the low bits.
`define SERIAL_SLOTS 128'h03e8_0338_02e8_0238_0228_0220_02f8_03f8
`define PARALLEL_SLOTS 128'h0000_0000_0000_0000_0000_03bc_0278_0378
`define FLOPPY_SLOTS 128'h0000_0000_0000_0000_0000_0000_0370_03f0

`endif

// >>> logic/window_hit.v
// Aligned power-of-two window compare used for the LAN, EHCI, PM, watchdog, serial, floppy and disk ranges.
// Assumes the base is already aligned to the window size.
`timescale 1ns/10ps
module window_hit #(
  parameter AW = 32,
  parameter SB = 12
) (
  // Address under test
  input wire [AW-1:0] addr_i,
  // Window placement
  input wire [AW-1:SB] base_i,
  input wire enable_i,
  // Result
  output wire hit_o
);
  assign hit_o = enable_i && (addr_i[AW-1:SB] == base_i);
endmodule // window_hit

// >>> logic/slot_base.v
// Picks one of eight fixed 16-bit I/O bases from a packed table.
// Assumes unused slots in the table are never selected by software.
`timescale 1ns/10ps
module slot_base #(
  parameter [127:0] TABLE = 128'h0
) (
  // Slot select
  input wire [2:0] sel_i,
  // Chosen base
  output wire [15:0] base_o
);
  wire [127:0] shifted;
  assign shifted = TABLE >> {sel_i, 4'h0};
  assign base_o = shifted[15:0];
endmodule // slot_base

// >>> logic/soc_address_decoder.v
// Platform hub address decoder: classifies each processor I/O or memory
// cycle and reports one registered route per cycle.
// Assumes all settings come from logic on mclk_i and are stable per cycle.
`timescale 1ns/10ps
`include "soc_address_decoder_defs.vh"
module soc_address_decoder (
  // Clock, reset, enable
  input wire mclk_i,
  input wire resetn_i,
  input wire ce_i,
  // Upstream cycle
  input wire cycle_valid_i,
  input wire cycle_mem_i,
  input wire cycle_write_i,
  input wire [31:0] cycle_addr_i,
  // Memory settings
  input wire [31:0] top_of_memory_i,
  input wire [`FW_EN_W-1:0] fw_decode_enable_i,
  input wire top_swap_i,
  input wire apic_window_enable_i,
  input wire [7:0] apic_window_select_i,
  input wire [7:0] port_apic_enable_i,
  input wire lan_window_a_enable_i,
  input wire [31:`LAN_A_LOG2] lan_window_a_base_i,
  input wire lan_window_b_enable_i,
  input wire [31:`LAN_B_LOG2] lan_window_b_base_i,
  input wire ehci_window_enable_i,
  input wire [31:`EHCI_LOG2] ehci_window_base_i,
  // I/O settings
  input wire pm_io_enable_i,
  input wire [15:`PM_SIZE_LOG2] pm_io_base_i,
  input wire watchdog_io_range_enable_i,
  input wire serial1_enable_i,
  input wire [2:0] serial1_slot_i,
  input wire serial2_enable_i,
  input wire [2:0] serial2_slot_i,
  input wire parallel_enable_i,
  input wire [1:0] parallel_slot_i,
  input wire floppy_enable_i,
  input wire floppy_slot_i,
  input wire disk_cmd_enable_i,
  input wire [15:`DISK_CMD_LOG2] disk_cmd_base_i,
  input wire disk_ctl_enable_i,
  input wire [15:`DISK_CTL_LOG2] disk_ctl_base_i,
  input wire disk_to_redirection_i,
  // Registered route
  output reg route_valid_o,
  output reg route_write_o,
  output reg route_mem_o,
  output reg [`TGT_W-1:0] route_target_o,
  output reg [2:0] route_port_o,
  output reg [31:0] route_addr_o
);

  wire [15:0] io_addr;
  wire [15:0] pm_base_full;
  wire [15:0] tco_base;
  wire [15:0] ser1_base;
  wire [15:0] ser2_base;
  wire [15:0] par_base;
  wire [15:0] fdc_base;
  wire lan_a_hit;
  wire lan_b_hit;
  wire ehci_hit;
  wire pm_hit;
  wire tco_hit;
  wire ser1_hit;
  wire ser2_hit;
  wire par_hit;
  wire fdc_hit;
  wire cmd_hit;
  wire ctl_hit;
  wire main_hit;
  wire apic_hit;
  wire [4:0] rp_slot;
  wire rp_in_range;
  wire [4:0] rp_index;
  wire rp_hit;
  wire fw_hi_tag;
  wire [2:0] fw_hi_idx;
  wire [3:0] fw_hi_bit;
  wire fw_hi_hit;
  wire fw_lo_hit;
  wire fw_seg_hit;
  wire fw_hit;
  wire swap_hit;
  wire [`TGT_W-1:0] disk_target;

  reg fixed_hit;
  reg [`TGT_W-1:0] fixed_tgt;
  reg [`TGT_W-1:0] next_target;
  reg [2:0] next_port;
  reg [31:0] next_addr;

  assign io_addr = cycle_addr_i[15:0];

  assign main_hit = (cycle_addr_i < `LOW_MEM_END) ||
                    ((cycle_addr_i >= `ONE_MEG) && (cycle_addr_i < top_of_memory_i));

  assign fw_seg_hit = ((cycle_addr_i[31:16] == `E_SEG_PAGE) && fw_decode_enable_i[`FW_E_SEG_BIT]) ||
                      ((cycle_addr_i[31:16] == `F_SEG_PAGE) && fw_decode_enable_i[`FW_F_SEG_BIT]);

  assign fw_hi_tag = (cycle_addr_i[31:22] == `FW_HI_TAG) || (cycle_addr_i[31:22] == `FW_HI_ALIAS_TAG);
  assign fw_hi_idx = cycle_addr_i[21:19];
  assign fw_hi_bit = `FW_HI_BIT0 + {1'b0, fw_hi_idx};
  assign fw_hi_hit = fw_hi_tag &&
                     ((fw_hi_idx == `FW_HI_TOP_IDX) || fw_decode_enable_i[fw_hi_bit]);

  // Lower 1M windows, alias folds on A22
  assign fw_lo_hit = (cycle_addr_i[31:23] == `FW_LO_TAG) &&
                     fw_decode_enable_i[cycle_addr_i[21:20]];

  assign fw_hit = fw_seg_hit || fw_hi_hit || fw_lo_hit;

  assign swap_hit = top_swap_i && fw_hi_tag && (fw_hi_idx == `FW_HI_TOP_IDX) &&
                    (cycle_addr_i[18:17] == `SWAP_BLOCKS);

  assign apic_hit = apic_window_enable_i && (cycle_addr_i[31:20] == `APIC_TAG) &&
                    (cycle_addr_i[19:12] == apic_window_select_i) &&
                    (cycle_addr_i[11:0] <= `APIC_WIN_LAST);

  assign rp_slot = cycle_addr_i[19:15];
  assign rp_in_range = (cycle_addr_i[31:20] == `APIC_TAG) &&
                       (rp_slot >= `RP_FIRST_SLOT) && (rp_slot <= `RP_LAST_SLOT);
  assign rp_index = rp_slot - `RP_FIRST_SLOT;
  assign rp_hit = rp_in_range && port_apic_enable_i[rp_index[2:0]];

  window_hit #(.AW(32), .SB(`LAN_A_LOG2)) u_lan_a (
    .addr_i(cycle_addr_i),
    .base_i(lan_window_a_base_i),
    .enable_i(lan_window_a_enable_i),
    .hit_o(lan_a_hit)
  );

  window_hit #(.AW(32), .SB(`LAN_B_LOG2)) u_lan_b (
    .addr_i(cycle_addr_i),
    .base_i(lan_window_b_base_i),
    .enable_i(lan_window_b_enable_i),
    .hit_o(lan_b_hit)
  );

  window_hit #(.AW(32), .SB(`EHCI_LOG2)) u_ehci (
    .addr_i(cycle_addr_i),
    .base_i(ehci_window_base_i),
    .enable_i(ehci_window_enable_i),
    .hit_o(ehci_hit)
  );

  assign pm_base_full = {pm_io_base_i, {`PM_SIZE_LOG2{1'b0}}};

  window_hit #(.AW(16), .SB(`PM_SIZE_LOG2)) u_pm (
    .addr_i(io_addr),
    .base_i(pm_io_base_i),
    .enable_i(pm_io_enable_i),
    .hit_o(pm_hit)
  );

  assign tco_base = pm_base_full + `TCO_OFFSET;

  window_hit #(.AW(16), .SB(`TCO_SIZE_LOG2)) u_tco (
    .addr_i(io_addr),
    .base_i(tco_base[15:`TCO_SIZE_LOG2]),
    .enable_i(watchdog_io_range_enable_i),
    .hit_o(tco_hit)
  );

  slot_base #(.TABLE(`SERIAL_SLOTS)) u_ser1_slot (
    .sel_i(serial1_slot_i),
    .base_o(ser1_base)
  );

  slot_base #(.TABLE(`SERIAL_SLOTS)) u_ser2_slot (
    .sel_i(serial2_slot_i),
    .base_o(ser2_base)
  );

  slot_base #(.TABLE(`PARALLEL_SLOTS)) u_par_slot (
    .sel_i({1'b0, parallel_slot_i}),
    .base_o(par_base)
  );

  slot_base #(.TABLE(`FLOPPY_SLOTS)) u_fdc_slot (
    .sel_i({2'b00, floppy_slot_i}),
    .base_o(fdc_base)
  );

  window_hit #(.AW(16), .SB(`LEG_SIZE_LOG2)) u_ser1 (
    .addr_i(io_addr),
    .base_i(ser1_base[15:`LEG_SIZE_LOG2]),
    .enable_i(serial1_enable_i),
    .hit_o(ser1_hit)
  );

  window_hit #(.AW(16), .SB(`LEG_SIZE_LOG2)) u_ser2 (
    .addr_i(io_addr),
    .base_i(ser2_base[15:`LEG_SIZE_LOG2]),
    .enable_i(serial2_enable_i),
    .hit_o(ser2_hit)
  );

  // The unused fourth parallel slot decodes to a zero base and is held off.
  // One parallel base is not eight-byte aligned, so the range is an offset compare.
  assign par_hit = parallel_enable_i && (par_base != 16'h0000) &&
                   (((io_addr - par_base) >> `LEG_SIZE_LOG2) == 16'h0000);

  window_hit #(.AW(16), .SB(`LEG_SIZE_LOG2)) u_fdc (
    .addr_i(io_addr),
    .base_i(fdc_base[15:`LEG_SIZE_LOG2]),
    .enable_i(floppy_enable_i),
    .hit_o(fdc_hit)
  );

  window_hit #(.AW(16), .SB(`DISK_CMD_LOG2)) u_cmd (
    .addr_i(io_addr),
    .base_i(disk_cmd_base_i),
    .enable_i(disk_cmd_enable_i),
    .hit_o(cmd_hit)
  );

  window_hit #(.AW(16), .SB(`DISK_CTL_LOG2)) u_ctl (
    .addr_i(io_addr),
    .base_i(disk_ctl_base_i),
    .enable_i(disk_ctl_enable_i),
    .hit_o(ctl_hit)
  );

  assign disk_target = disk_to_redirection_i ? `TGT_DISK_REDIR : `TGT_SATA;

  // Fixed legacy I/O map. Reserved reads leave fixed_hit low so they fall
  // through to the watchdog, PM, disk and legacy slot ranges before the default target.
  always @* begin
    fixed_hit = 1'b1;
    fixed_tgt = `TGT_DEFAULT;
    if (io_addr[15:8] == 8'h00) begin
      casez (io_addr[7:0])
        8'b000?_????: begin
          if (!cycle_write_i && (io_addr[3:0] >= 4'h9) && (io_addr[3:0] <= 4'he))
            fixed_hit = 1'b0;
          else
            fixed_tgt = `TGT_DMA;
        end
        8'h2e, 8'h2f, 8'h4e, 8'h4f, 8'h60, 8'h62, 8'h64, 8'h66: fixed_tgt = `TGT_LPC;
        8'b?01?_??0?: fixed_tgt = `TGT_INTC;
        8'b010?_0011: begin
          if (cycle_write_i)
            fixed_tgt = `TGT_TIMER;
          else
            fixed_hit = 1'b0;
        end
        8'b010?_00??: fixed_tgt = `TGT_TIMER;
        8'h61: fixed_tgt = `TGT_NMI;
        8'b0111_0???: begin
          if (io_addr[0])
            fixed_tgt = `TGT_RTC;
          else if (cycle_write_i)
            fixed_tgt = `TGT_NMI_RTC;
          else if (io_addr[2:0] == 3'h0)
            fixed_hit = 1'b0;
          else
            fixed_tgt = `TGT_RTC;
        end
        8'h80: fixed_tgt = `TGT_DMA_FWD;
        8'h84, 8'h85, 8'h86, 8'h88, 8'h8c, 8'h8d, 8'h8e:
          fixed_tgt = cycle_write_i ? `TGT_DMA_FWD : `TGT_DMA;
        8'h92: fixed_tgt = `TGT_RESET_GEN;
        8'b100?_????: fixed_tgt = `TGT_DMA;
        8'hb2, 8'hb3: fixed_tgt = `TGT_PM;
        8'b110?_????: begin
          if (!cycle_write_i && (io_addr[7:0] >= 8'hd2) && (io_addr[7:0] <= 8'hdd))
            fixed_hit = 1'b0;
          else if (io_addr[7:0] <= 8'hd1 || io_addr[7:0] >= 8'hd2)
            fixed_tgt = `TGT_DMA;
        end
        8'hf0: fixed_tgt = `TGT_PROC_IF;
        default: fixed_hit = 1'b0;
      endcase
    end else begin
      casez (io_addr)
        16'h017?, 16'h01f?: begin
          if (io_addr[3])
            fixed_hit = 1'b0;
          else
            fixed_tgt = `TGT_SATA;
        end
        16'h0376, 16'h03f6: fixed_tgt = `TGT_SATA;
        16'h020?: fixed_tgt = `TGT_LPC;
        16'h04d0, 16'h04d1: fixed_tgt = `TGT_INTC;
        16'h0cf9: fixed_tgt = `TGT_RESET_GEN;
        default: fixed_hit = 1'b0;
      endcase
    end
  end

  always @* begin
    next_target = `TGT_DEFAULT;
    next_port = 3'h0;
    next_addr = cycle_addr_i;
    if (cycle_mem_i) begin
      if (main_hit) begin
        next_target = `TGT_MAIN_MEM;
      end else if (apic_hit) begin
        next_target = `TGT_APIC;
      end else if (rp_hit) begin
        next_target = `TGT_ROOT_PORT;
        next_port = rp_index[2:0];
      end else if (fw_hit) begin
        next_target = `TGT_FW_PATH;
        if (swap_hit)
          next_addr[`SWAP_ADDR_BIT] = ~cycle_addr_i[`SWAP_ADDR_BIT];
      end else if (lan_a_hit || lan_b_hit) begin
        next_target = `TGT_LAN;
      end else if (ehci_hit) begin
        next_target = `TGT_EHCI;
      end
    end else begin
      if (fixed_hit)
        next_target = fixed_tgt;
      else if (tco_hit)
        next_target = `TGT_WATCHDOG;
      else if (pm_hit)
        next_target = `TGT_PM;
      else if (cmd_hit || ctl_hit)
        next_target = disk_target;
      else if (ser1_hit || ser2_hit || par_hit || fdc_hit)
        next_target = `TGT_LPC;
    end
  end

  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      route_valid_o <= 1'b0;
      route_write_o <= 1'b0;
      route_mem_o <= 1'b0;
      route_target_o <= `TGT_DEFAULT;
      route_port_o <= 3'h0;
      route_addr_o <= 32'h0000_0000;
    end else if (ce_i) begin
      route_valid_o <= cycle_valid_i;
      if (cycle_valid_i) begin
        route_write_o <= cycle_write_i;
        route_mem_o <= cycle_mem_i;
        route_target_o <= next_target;
        route_port_o <= next_port;
        route_addr_o <= next_addr;
      end
    end
  end

endmodule // soc_address_decoder

// >>> testbench/soc_address_decoder_props.sv
// Port-level assertions for the platform hub address decoder.
// Assumes it is bound to soc_address_decoder and sees only its ports.
`timescale 1ns/10ps
`include "soc_address_decoder_defs.vh"
module soc_address_decoder_props (
  // Clock and control
  input wire mclk_i,
  input wire resetn_i,
  input wire ce_i,
  // Cycle and settings
  input wire cycle_valid_i,
  input wire cycle_mem_i,
  input wire cycle_write_i,
  input wire [31:0] cycle_addr_i,
  input wire [31:0] top_of_memory_i,
  input wire [15:0] fw_decode_enable_i,
  input wire top_swap_i,
  input wire apic_window_enable_i,
  input wire [7:0] port_apic_enable_i,
  input wire pm_io_enable_i,
  input wire [15:6] pm_io_base_i,
  input wire watchdog_io_range_enable_i,
  // Route
  input wire route_valid_o,
  input wire [4:0] route_target_o,
  input wire [2:0] route_port_o,
  input wire [31:0] route_addr_o
);
  wire take = ce_i && cycle_valid_i;
  wire high_mem = take && cycle_mem_i && cycle_addr_i >= top_of_memory_i;
  wire seg_en = fw_decode_enable_i[{3'h3, cycle_addr_i[16]}];
  wire [4:0] rp_off = cycle_addr_i[19:15] - 5'h02;
  wire [15:0] wd_base = {pm_io_base_i, 6'h00} + 16'h0060;
  wire rp_hit = cycle_addr_i[31:20] == 12'hfec && cycle_addr_i[19:15] >= 5'h02 && cycle_addr_i[19:15] <= 5'h09;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  chk_valid_one: assert property (take |=> route_valid_o)
    else $error("route valid missing after a taken cycle");
  chk_valid_drop: assert property (ce_i && !cycle_valid_i |=> !route_valid_o)
    else $error("route valid without a cycle");
  chk_ce_freeze: assert property (!ce_i |=> $stable(route_target_o) && $stable(route_valid_o))
    else $error("outputs moved while clock enable low");
  chk_low_mem: assert property (take && cycle_mem_i && cycle_addr_i < 32'h000e0000 |=> route_target_o == `TGT_MAIN_MEM)
    else $error("low memory not routed to main memory");
  chk_seg_enable: assert property (take && cycle_mem_i && cycle_addr_i[31:17] == 15'h0007 |=>
    (route_target_o == `TGT_FW_PATH) == $past(seg_en))
    else $error("E or F segment routing disagrees with its enable");
  chk_fw_top: assert property (high_mem && cycle_addr_i[31:19] == 13'h1fff |=> route_target_o == `TGT_FW_PATH)
    else $error("top firmware window not routed to firmware");
  chk_swap_a16: assert property (high_mem && top_swap_i && cycle_addr_i[31:17] == 15'h7fff |=>
    route_addr_o == ($past(cycle_addr_i) ^ 32'h00010000))
    else $error("address bit 16 not inverted in swap mode");
  chk_root_port: assert property (high_mem && !apic_window_enable_i && rp_hit && port_apic_enable_i[rp_off[2:0]] |=>
    route_target_o == `TGT_ROOT_PORT && route_port_o == $past(rp_off[2:0]))
    else $error("root port window misrouted");
  chk_rtc_write: assert property (take && !cycle_mem_i && cycle_write_i && cycle_addr_i[15:3] == 13'h000e &&
    !cycle_addr_i[0] |=> route_target_o == `TGT_NMI_RTC)
    else $error("even clock port write not sent to both units");
  chk_watchdog: assert property (take && !cycle_mem_i && pm_io_enable_i && watchdog_io_range_enable_i &&
    cycle_addr_i[15:5] == wd_base[15:5] && cycle_addr_i[15:12] != 4'h0 |=> route_target_o == `TGT_WATCHDOG)
    else $error("watchdog range not decoded above the power base");
endmodule // soc_address_decoder_props

// >>> testbench/cpu_cycle_source.sv
// Processor-side model that presents one cycle per clock on request.
// Assumes callers enter its tasks just after a falling edge of mclk_i.
`timescale 1ns/10ps
module cpu_cycle_source (
  // Clock
  input wire mclk_i,
  // Cycle request
  output logic cycle_valid_o,
  output logic cycle_mem_o,
  output logic cycle_write_o,
  output logic [31:0] cycle_addr_o
);
  initial begin
    cycle_valid_o = 1'b0;
    cycle_mem_o = 1'b0;
    cycle_write_o = 1'b0;
    cycle_addr_o = 32'h00000000;
  end
  // Fields hold across one sampling edge, so cycles may follow back to back.
  task issue(input logic mem, input logic wr, input logic [31:0] addr);
    cycle_valid_o = 1'b1;
    cycle_mem_o = mem;
    cycle_write_o = wr;
    cycle_addr_o = addr;
    @(negedge mclk_i);
  endtask
  // An idle bus does not keep its last address, so a stale match cannot hide.
  task idle();
    cycle_valid_o = 1'b0;
    cycle_addr_o = ~cycle_addr_o;
    @(negedge mclk_i);
  endtask
endmodule // cpu_cycle_source

// >>> testbench/tb.sv
// Self-checking bench for the address decoder with a processor-side model.
// Assumes the defs header is on the include path.
`timescale 1ns/10ps
`include "soc_address_decoder_defs.vh"
`define CHK(name, exp, got) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", name, exp, got); end end
module tb;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ce_i = 1'b1;
  logic cycle_valid_i, cycle_mem_i, cycle_write_i;
  logic [31:0] cycle_addr_i;
  logic [31:0] top_of_memory_i = 32'h40000000;
  logic [15:0] fw_decode_enable_i = 16'h0000;
  logic top_swap_i = 1'b1;
  logic apic_window_enable_i = 1'b1;
  logic [7:0] apic_window_select_i = 8'h20;
  logic [7:0] port_apic_enable_i = 8'hff;
  logic lan_window_a_enable_i = 1'b1;
  logic [31:17] lan_window_a_base_i = 15'h4000;
  logic lan_window_b_enable_i = 1'b1;
  logic [31:12] lan_window_b_base_i = 20'h90000;
  logic ehci_window_enable_i = 1'b1;
  logic [31:10] ehci_window_base_i = 22'h280000;
  logic pm_io_enable_i = 1'b1;
  logic [15:6] pm_io_base_i = 10'h020;
  logic watchdog_io_range_enable_i = 1'b1;
  logic serial1_enable_i = 1'b0;
  logic [2:0] serial1_slot_i = 3'h0;
  logic serial2_enable_i = 1'b0;
  logic [2:0] serial2_slot_i = 3'h0;
  logic parallel_enable_i = 1'b0;
  logic [1:0] parallel_slot_i = 2'h0;
  logic floppy_enable_i = 1'b0;
  logic floppy_slot_i = 1'b0;
  logic disk_cmd_enable_i = 1'b1;
  logic [15:3] disk_cmd_base_i = 13'h0200;
  logic disk_ctl_enable_i = 1'b1;
  logic [15:2] disk_ctl_base_i = 14'h0800;
  logic disk_to_redirection_i = 1'b0;
  logic route_valid_o, route_write_o, route_mem_o;
  logic [4:0] route_target_o;
  logic [2:0] route_port_o;
  logic [31:0] route_addr_o;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [15:0] seed = 16'hca08;
  localparam logic [31:0] IO_CASES [36] = '{32'h00070000, 32'h10070008, 32'h10076008, 32'h00071007,
    32'h10077007, 32'h00080004, 32'h10080004, 32'h10084004, 32'h00086003, 32'h10088004, 32'h00088003,
    32'h1008e004, 32'h0008c003, 32'h0017000c, 32'h101f700c, 32'h0037600c, 32'h103f600c, 32'h00178000,
    32'h00009000, 32'h1000e003, 32'h00043000, 32'h10043006, 32'h00020005, 32'h1009200a, 32'h00cf900a,
    32'h0002e00d, 32'h000b200b, 32'h0080000b, 32'h00860012, 32'h1087f012, 32'h00880000, 32'h00840000,
    32'h1100000c, 32'h01008000, 32'h0200300c, 32'h02004000};
  localparam logic [31:0] MEM_CASES [20] = '{32'h000dffff, 32'h000e0000, 32'h000fffff, 32'h00100000,
    32'h3fffffff, 32'h40000000, 32'hfec20000, 32'hfec20040, 32'hfec20041, 32'hfec4ffff, 32'hfec50000,
    32'hff400000, 32'hff0fffff, 32'hffc00000, 32'hff87ffff, 32'hfffe0000, 32'hffbf0000, 32'hfff80000,
    32'h8001ffff, 32'h80020000};

  cpu_cycle_source u_cpu_cycle_source (.mclk_i(mclk_i), .cycle_valid_o(cycle_valid_i),
    .cycle_mem_o(cycle_mem_i), .cycle_write_o(cycle_write_i), .cycle_addr_o(cycle_addr_i));
  soc_address_decoder u_soc_address_decoder (.*);

  always #4 mclk_i = ~mclk_i;

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      print_verdict();
    end
  end

  task print_verdict();
    if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function logic [31:0] draw();
    logic [15:0] hi;
    seed = lfsr(seed);
    hi = seed;
    seed = lfsr(seed);
    return {hi, seed};
  endfunction

  function logic fw_hit(input logic [31:0] a);
    if (a[31:17] == 15'h0007) return fw_decode_enable_i[{3'h3, a[16]}];
    if (a[31:23] == 9'h1ff) return a[21:19] == 3'h7 || fw_decode_enable_i[{1'b1, a[21:19]}];
    if (a[31:23] == 9'h1fe) return fw_decode_enable_i[{2'h0, a[21:20]}];
    return 1'b0;
  endfunction

  // Port index in the top three bits, route code below.
  function logic [7:0] exp_mem(input logic [31:0] a);
    logic [4:0] s;
    s = a[19:15] - 5'h02;
    if (a < 32'h000e0000 || (a >= 32'h00100000 && a < top_of_memory_i)) return {3'h0, `TGT_MAIN_MEM};
    if (apic_window_enable_i && a[31:20] == 12'hfec && a[19:12] == apic_window_select_i && a[11:0] <= 12'h040)
      return {3'h0, `TGT_APIC};
    if (a[31:20] == 12'hfec && a[19:15] >= 5'h02 && a[19:15] <= 5'h09 && port_apic_enable_i[s[2:0]])
      return {s[2:0], `TGT_ROOT_PORT};
    if (fw_hit(a)) return {3'h0, `TGT_FW_PATH};
    if ((lan_window_a_enable_i && a[31:17] == lan_window_a_base_i) ||
        (lan_window_b_enable_i && a[31:12] == lan_window_b_base_i)) return {3'h0, `TGT_LAN};
    if (ehci_window_enable_i && a[31:10] == ehci_window_base_i) return {3'h0, `TGT_EHCI};
    return {3'h0, `TGT_DEFAULT};
  endfunction

  function logic [15:0] slot_addr(input int k, input int i);
    logic [127:0] t;
    t = (k < 2) ? `SERIAL_SLOTS : (k == 2) ? `PARALLEL_SLOTS : `FLOPPY_SLOTS;
    return t[16*i +: 16];
  endfunction

  task send(input logic mem, input logic wr, input logic [31:0] a, input logic [7:0] exp);
    logic [31:0] ea;
    ea = a;
    if (mem && top_swap_i && (a[31:17] == 15'h7fff || a[31:17] == 15'h7fdf)) ea = a ^ 32'h00010000;
    u_cpu_cycle_source.issue(mem, wr, a);
    `CHK("valid", 1'b1, route_valid_o)
    `CHK("target", exp[4:0], route_target_o)
    `CHK("port", exp[7:5], route_port_o)
    `CHK("write", wr, route_write_o)
    `CHK("mem", mem, route_mem_o)
    if (mem) `CHK("addr", ea, route_addr_o)
  endtask

  initial begin
    logic [31:0] r;
    logic [31:0] a;
    logic [15:0] b;
    int i;
    int k;
    repeat (4) @(negedge mclk_i);
    `CHK("reset valid", 1'b0, route_valid_o)
    `CHK("reset target", 5'h00, route_target_o)
    resetn_i = 1'b1;
    for (k = 0; k < 2; k++) begin
      fw_decode_enable_i = k ? 16'hffff : 16'h0000;
      for (i = 0; i < 20; i++) send(1'b1, i[0], MEM_CASES[i], exp_mem(MEM_CASES[i]));
    end
    for (i = 0; i < 36; i++) send(1'b0, IO_CASES[i][28], {16'h0000, IO_CASES[i][27:12]},
      {3'h0, IO_CASES[i][4:0]});
    send(1'b0, 1'b0, 32'h000000f0, {3'h0, `TGT_PROC_IF});
    send(1'b0, 1'b1, 32'h00000061, {3'h0, `TGT_NMI});
    send(1'b0, 1'b0, 32'h000000d5, {3'h0, `TGT_DEFAULT});
    disk_to_redirection_i = 1'b1;
    send(1'b0, 1'b0, 32'h00001007, {3'h0, `TGT_DISK_REDIR});
    send(1'b0, 1'b1, 32'h00002000, {3'h0, `TGT_DISK_REDIR});
    watchdog_io_range_enable_i = 1'b0;
    send(1'b0, 1'b0, 32'h00000860, {3'h0, `TGT_DEFAULT});
    pm_io_base_i = 10'h3c0;
    watchdog_io_range_enable_i = 1'b1;
    send(1'b0, 1'b1, 32'h0000f070, {3'h0, `TGT_WATCHDOG});
    send(1'b0, 1'b0, 32'h0000f020, {3'h0, `TGT_PM});
    for (k = 0; k < 4; k++) begin
      for (i = 0; i < ((k < 2) ? 8 : (k == 2) ? 3 : 2); i++) begin
        r = draw();
        b = slot_addr(k, i);
        {serial1_slot_i, serial2_slot_i, parallel_slot_i, floppy_slot_i} = {i[2:0], i[2:0], i[1:0], i[0]};
        {serial1_enable_i, serial2_enable_i, parallel_enable_i, floppy_enable_i} = 4'h0;
        send(1'b0, r[3], {16'h0000, b}, {3'h0, `TGT_DEFAULT});
        {serial1_enable_i, serial2_enable_i, parallel_enable_i, floppy_enable_i} = 4'h8 >> k;
        send(1'b0, r[4], {16'h0000, b + {13'h0000, r[2:0]}},
          {3'h0, (k == 3 && r[2:0] == 3'h6) ? `TGT_SATA : `TGT_LPC});
        send(1'b0, r[5], {16'h0000, b + 16'h0008}, {3'h0, `TGT_DEFAULT});
      end
    end
    ce_i = 1'b0;
    u_cpu_cycle_source.issue(1'b1, 1'b0, 32'h00000000);
    `CHK("frozen valid", 1'b1, route_valid_o)
    `CHK("frozen target", `TGT_DEFAULT, route_target_o)
    ce_i = 1'b1;
    u_cpu_cycle_source.idle();
    `CHK("idle valid", 1'b0, route_valid_o)
    for (i = 0; i < 400; i++) begin
      r = draw();
      {port_apic_enable_i, fw_decode_enable_i} = {r[31:24], r[15:0]};
      {top_swap_i, apic_window_enable_i, lan_window_a_enable_i, lan_window_b_enable_i} = r[19:16];
      ehci_window_enable_i = r[20];
      apic_window_select_i = {3'h0, r[23:19]};
      r = draw();
      case (r[31:29])
        3'h0: a = {12'h000, r[19:0]};
        3'h1: a = {12'hfec, r[19:0]};
        3'h2: a = {9'h1ff, r[22:0]};
        3'h3: a = {9'h1fe, r[22:0]};
        3'h4: a = {15'h4000, r[16:0]};
        3'h5: a = {19'h48000, r[12:0]};
        3'h6: a = {21'h140000, r[10:0]};
        default: a = r;
      endcase
      send(1'b1, r[28], a, exp_mem(a));
    end
    print_verdict();
  end
endmodule // tb
bind soc_address_decoder soc_address_decoder_props u_soc_address_decoder_props (.*);
